// *** hw/dims_load.v ***
// dimmer load: command interpreter, output control and extended status message
`include "dims_defines.vh"
`default_nettype none

// What this block does
// - byte 1 reports group bitmap, zero bit member
// - byte 2 brightness, 251 ramping, 252 flashing
// - byte 3 lock field, locked ignores commands
// - byte 3 bits 2-3 report overcurrent
// - byte 3 bits 4-5 report external override
// - byte 3 bits 6-7 report external disable
// - byte 4 seconds remaining with special codes
// - byte 5 holds last executed command code
// - byte 6 bits 0-1 report interlock
// - byte 6 bits 2-3 report load on
// - 0x00 sets desired level, 0x01 full
// - 0x02 goes full after given delay
// - 0x03 sets output to zero
// - 0x04 freezes ramp, else turns off
// - 0x05 toggles between zero and desired
// - 0x06 stores brightness then turns off
// - 0x11 ramps to level, 0x12 ramp-toggles
// - 0x13 ramps up until full or stop
// - 0x14 ramps down until lowest or stop
// - 0x15 ramps down, up, repeating until stop
// - 0x21 locks, 0x22 unlocks
// - 0x31 flashes until stop, 0x32 momentary
// - status sent single frame, priority 6
module dims_load #(
	parameter SEC_CYC = `DIMS_SEC_CYC,
	parameter STEP_CYC = `DIMS_STEP_CYC,
	parameter FLASH_CYC = `DIMS_FLASH_CYC
) (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// external condition pins
	input wire ovc_in,
	input wire override_in,
	input wire disable_in,
	// load output
	output reg [6:0] level_out,
	// status message to the network controller
	output reg status_valid,
	output reg [63:0] status_data,
	output reg [16:0] status_dgn,
	output reg [2:0] status_prio
);

	localparam M_IDLE = 3'd0;
	localparam M_RAMP = 3'd1;
	localparam M_UPDN = 3'd2;
	localparam M_FLASH = 3'd3;
	localparam M_FLMOM = 3'd4;

	localparam D_NONE = 2'd0;
	localparam D_RUN = 2'd1;
	localparam D_EXP = 2'd2;
	localparam D_OOR = 2'd3;

	// desired level: memory selectors return the stored value, above full clamps
	// both selectors read the master memory; there is no separate dimmed memory
	function [6:0] lvl_of;
		input [7:0] d;
		input [6:0] mem;
		begin
			if (d >= `DIMS_MEMSEL)
				lvl_of = mem;
			else if (d > {1'b0, `DIMS_FULL})
				lvl_of = `DIMS_FULL;
			else
				lvl_of = d[6:0];
		end
	endfunction

	// delay byte to seconds; minute codes 241..250 are 5..14 minutes
	function [15:0] sec_of;
		input [7:0] d;
		reg [7:0] m;
		begin
			m = d - `DIMS_D_MINBASE;
			if (d <= `DIMS_D_MAX)
				sec_of = {8'h00, d};
			else
				sec_of = {8'h00, m} * 16'd60;
		end
	endfunction

	function [1:0] fld;
		input sup;
		input act;
		begin
			fld = sup ? {1'b0, act} : 2'b11;
		end
	endfunction

	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire mapped = (paddr == `DIMS_OFF_CMD) || (paddr == `DIMS_OFF_CFG) || (paddr == `DIMS_OFF_STLO) ||
		(paddr == `DIMS_OFF_STHI) || (paddr == `DIMS_OFF_OUT);
	// every access completes at once, so the master never sees a wait state
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;

	reg [31:0] cfg_q;
	reg [6:0] mem_q;
	reg [2:0] mode_q;
	reg [6:0] tgt_q;
	reg dir_q;
	reg lock_q;
	reg ilk_q;
	reg [7:0] last_q;
	reg [1:0] dst_q;
	reg [15:0] dsec_q;
	reg [31:0] sec_cnt_q;
	reg [31:0] step_cnt_q;
	reg [31:0] fl_cnt_q;
	reg [1:0] fl_left_q;
	reg [2:0] ovc_sync_q, ovr_sync_q, dis_sync_q;
	reg ovc_q, ovr_q, dis_q;
	reg [63:0] prev_q;
	reg send_req_q;

	wire cmd_wr = wr & (paddr == `DIMS_OFF_CMD);
	wire [7:0] c_code = pwdata[`DIMS_CMD_CODE];
	wire [7:0] c_dly = pwdata[`DIMS_CMD_DLY];
	wire [6:0] c_lvl = lvl_of(pwdata[`DIMS_CMD_LVL], mem_q);
	wire [4:0] sup = cfg_q[`DIMS_CFG_SUP];
	// while locked with the lock flag supported, only lock and unlock get through
	wire unl = (c_code == `DIMS_C_UNLOCK) || (c_code == `DIMS_C_LOCK);
	wire take = cmd_wr & (~lock_q | unl | ~sup[`DIMS_SUP_LOCK]);
	wire known = (c_code <= `DIMS_C_MEMOFF) || ((c_code >= `DIMS_C_RAMP) && (c_code <= `DIMS_C_RUPDN)) ||
		unl || (c_code == `DIMS_C_FLASH) || (c_code == `DIMS_C_FLMOM);
	wire sec_tick = (sec_cnt_q == SEC_CYC - 1);
	wire step_tick = (step_cnt_q == STEP_CYC - 1);
	wire fl_tick = (fl_cnt_q == FLASH_CYC - 1);
	wire ramping = (mode_q == M_RAMP) || (mode_q == M_UPDN);
	wire flashing = (mode_q == M_FLASH) || (mode_q == M_FLMOM);
	wire going_zero = ((mode_q == M_RAMP) && (tgt_q == 7'd0)) || ((mode_q == M_UPDN) && ~dir_q);

	// status byte assembly
	reg [7:0] b2, b4;
	reg [1:0] load_f;
	wire [63:0] stat;
	always @* begin
		b2 = {1'b0, level_out};
		if (ramping)
			b2 = `DIMS_B_RAMPING;
		else if (flashing)
			b2 = `DIMS_B_FLASHING;
		case (dst_q)
			D_RUN: b4 = (dsec_q >= {8'h00, `DIMS_D_MAX}) ? `DIMS_D_MAX : dsec_q[7:0];
			D_EXP: b4 = 8'h00;
			D_OOR: b4 = `DIMS_D_RANGE;
			default: b4 = `DIMS_D_NONE;
		endcase
		load_f = 2'b00;
		if (flashing || ((level_out != 7'd0) && ~going_zero))
			load_f = 2'b01;
	end
	assign stat = {8'hff,
		4'hf, load_f, fld(sup[`DIMS_SUP_ILK], ilk_q),
		last_q, b4,
		fld(sup[`DIMS_SUP_EN], dis_q), fld(sup[`DIMS_SUP_OVR], ovr_q),
		fld(sup[`DIMS_SUP_OVC], ovc_q), fld(sup[`DIMS_SUP_LOCK], lock_q),
		b2, cfg_q[`DIMS_CFG_GRP], cfg_q[`DIMS_CFG_INST]};

	// pins: three stages, a change counts once stages two and three agree
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ovc_sync_q <= 3'b000;
			ovr_sync_q <= 3'b000;
			dis_sync_q <= 3'b000;
			ovc_q <= 1'b0;
			ovr_q <= 1'b0;
			dis_q <= 1'b0;
		end else begin
			ovc_sync_q <= {ovc_sync_q[1:0], ovc_in};
			ovr_sync_q <= {ovr_sync_q[1:0], override_in};
			dis_sync_q <= {dis_sync_q[1:0], disable_in};
			// a one-cycle glitch never agrees across two stages, so it never reaches status
			if (ovc_sync_q[1] == ovc_sync_q[2])
				ovc_q <= ovc_sync_q[2];
			if (ovr_sync_q[1] == ovr_sync_q[2])
				ovr_q <= ovr_sync_q[2];
			if (dis_sync_q[1] == dis_sync_q[2])
				dis_q <= dis_sync_q[2];
		end
	end

	// apb registers and read data, loaded in the setup phase so reads need no wait
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= `DIMS_CFG_RST;
			prdata <= 32'h00000000;
			send_req_q <= 1'b0;
		end else begin
			send_req_q <= wr & (paddr == `DIMS_OFF_STLO);
			// unused config bits are dropped so they always read back as zero
			if (wr && (paddr == `DIMS_OFF_CFG))
				cfg_q <= pwdata & `DIMS_CFG_MASK;
			if (psel && !penable) begin
				case (paddr)
					`DIMS_OFF_CFG: prdata <= cfg_q;
					`DIMS_OFF_STLO: prdata <= stat[31:0];
					`DIMS_OFF_STHI: prdata <= stat[63:32];
					`DIMS_OFF_OUT: prdata <= {5'h00, mode_q, 1'b0, mem_q, 1'b0, level_out, last_q};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// command execution, ramps, flashing and delay timing
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			level_out <= 7'd0;
			mem_q <= 7'd0;
			mode_q <= M_IDLE;
			tgt_q <= 7'd0;
			dir_q <= 1'b0;
			lock_q <= 1'b0;
			ilk_q <= 1'b0;
			last_q <= 8'h00;
			dst_q <= D_NONE;
			dsec_q <= 16'h0000;
			sec_cnt_q <= 32'h00000000;
			step_cnt_q <= 32'h00000000;
			fl_cnt_q <= 32'h00000000;
			fl_left_q <= 2'd0;
		end else begin
			// prescalers run free; only a delay start restarts the seconds count
			sec_cnt_q <= sec_tick ? 32'h00000000 : sec_cnt_q + 32'h00000001;
			step_cnt_q <= step_tick ? 32'h00000000 : step_cnt_q + 32'h00000001;
			fl_cnt_q <= fl_tick ? 32'h00000000 : fl_cnt_q + 32'h00000001;
			// background motion
			if (ramping && step_tick) begin
				if (level_out < tgt_q)
					level_out <= level_out + 7'd1;
				else if (level_out > tgt_q)
					level_out <= level_out - 7'd1;
				else if (mode_q == M_UPDN) begin
					dir_q <= ~dir_q;
					tgt_q <= dir_q ? 7'd0 : `DIMS_FULL;
				end else
					mode_q <= M_IDLE;
			end
			if (flashing && fl_tick) begin
				level_out <= (level_out == 7'd0) ? `DIMS_FULL : 7'd0;
				if (mode_q == M_FLMOM) begin
					fl_left_q <= fl_left_q - 2'd1;
					if (fl_left_q == 2'd1) begin
						mode_q <= M_IDLE;
						level_out <= 7'd0;
					end
				end
			end
			if ((dst_q == D_RUN) && sec_tick) begin
				dsec_q <= dsec_q - 16'd1;
				if (dsec_q == 16'd1) begin
					dst_q <= D_EXP;
					level_out <= `DIMS_FULL;
					mode_q <= M_IDLE;
				end
			end
			// a taken command overrides the background updates above
			if (take && known) begin
				last_q <= c_code;
				ilk_q <= pwdata[`DIMS_CMD_ILK] != 2'b00;
				if (!unl) begin
					dst_q <= D_NONE;
					mode_q <= M_IDLE;
				end
				case (c_code)
					`DIMS_C_SET: level_out <= c_lvl;
					`DIMS_C_ON: level_out <= `DIMS_FULL;
					`DIMS_C_ONDLY: begin
						// sender keeps the delay within range; reserved codes are reported
						if (c_dly > `DIMS_MEMSEL && c_dly != `DIMS_D_NONE)
							dst_q <= D_OOR;
						else if (c_dly == 8'd0 || c_dly == `DIMS_D_NONE) begin
							level_out <= `DIMS_FULL;
							dst_q <= D_EXP;
						end else begin
							dsec_q <= sec_of(c_dly);
							dst_q <= D_RUN;
							// a free-running count would cut the first second short
							sec_cnt_q <= 32'h00000000;
						end
					end
					`DIMS_C_OFF: level_out <= 7'd0;
					`DIMS_C_STOP: begin
						if (flashing)
							level_out <= 7'd0;
						// a stop during a ramp leaves the level where it stands
						else if (!ramping)
							level_out <= 7'd0;
					end
					`DIMS_C_TOG: level_out <= (level_out != 7'd0) ? 7'd0 : c_lvl;
					`DIMS_C_MEMOFF: begin
						mem_q <= level_out;
						level_out <= 7'd0;
					end
					`DIMS_C_RAMP: begin
						mode_q <= M_RAMP;
						tgt_q <= c_lvl;
					end
					`DIMS_C_RTOG: begin
						mode_q <= M_RAMP;
						// a ramp already heading to zero counts as off
						tgt_q <= ((level_out != 7'd0) && !going_zero) ? 7'd0 : c_lvl;
					end
					`DIMS_C_RUP: begin
						mode_q <= M_RAMP;
						tgt_q <= `DIMS_FULL;
					end
					`DIMS_C_RDN: begin
						mode_q <= M_RAMP;
						tgt_q <= 7'd0;
					end
					`DIMS_C_RUPDN: begin
						mode_q <= M_UPDN;
						tgt_q <= 7'd0;
						dir_q <= 1'b0;
					end
					// lock is refused silently while the lock field reports unsupported
					`DIMS_C_LOCK: lock_q <= sup[`DIMS_SUP_LOCK];
					`DIMS_C_UNLOCK: lock_q <= 1'b0;
					`DIMS_C_FLASH: mode_q <= M_FLASH;
					`DIMS_C_FLMOM: begin
						// a repeat restarts the one flash so it continues while repeated
						mode_q <= M_FLMOM;
						// counted in half periods: one lit, one dark
						fl_left_q <= `DIMS_FLMOM_HALVES;
					end
					default: mode_q <= mode_q;
				endcase
			end
		end
	end

	// status message: sent on any field change or when software asks
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= 64'h0000000000000000;
			status_valid <= 1'b0;
			status_data <= 64'h0000000000000000;
			status_dgn <= 17'h00000;
			status_prio <= 3'd0;
		end else begin
			// the last value is kept so any change sends, asked for or not
			prev_q <= stat;
			status_valid <= (stat != prev_q) | send_req_q;
			if ((stat != prev_q) || send_req_q) begin
				status_data <= stat;
				status_dgn <= `DIMS_DGN;
				status_prio <= `DIMS_PRIO;
			end
		end
	end

endmodule
`default_nettype wire

// *** hw/dims_defines.vh ***
// constants for the dimmer load command and status block
`ifndef DIMS_DEFINES_VH
`define DIMS_DEFINES_VH
// register byte offsets
`define DIMS_OFF_CMD 8'h00
`define DIMS_OFF_CFG 8'h04
`define DIMS_OFF_STLO 8'h08
`define DIMS_OFF_STHI 8'h0c
`define DIMS_OFF_OUT 8'h10
// command register fields
`define DIMS_CMD_LVL 7:0
`define DIMS_CMD_CODE 15:8
`define DIMS_CMD_DLY 23:16
`define DIMS_CMD_ILK 25:24
// config register fields and reset
`define DIMS_CFG_GRP 7:0
`define DIMS_CFG_SUP 12:8
`define DIMS_CFG_INST 23:16
`define DIMS_CFG_RST 32'h00011f00
`define DIMS_CFG_MASK 32'h00ff1fff
// support flag positions inside the sup field
`define DIMS_SUP_LOCK 0
`define DIMS_SUP_OVC 1
`define DIMS_SUP_OVR 2
`define DIMS_SUP_EN 3
`define DIMS_SUP_ILK 4
// command codes
`define DIMS_C_SET 8'h00
`define DIMS_C_ON 8'h01
`define DIMS_C_ONDLY 8'h02
`define DIMS_C_OFF 8'h03
`define DIMS_C_STOP 8'h04
`define DIMS_C_TOG 8'h05
`define DIMS_C_MEMOFF 8'h06
`define DIMS_C_RAMP 8'h11
`define DIMS_C_RTOG 8'h12
`define DIMS_C_RUP 8'h13
`define DIMS_C_RDN 8'h14
`define DIMS_C_RUPDN 8'h15
`define DIMS_C_LOCK 8'h21
`define DIMS_C_UNLOCK 8'h22
`define DIMS_C_FLASH 8'h31
`define DIMS_C_FLMOM 8'h32
// status special values
`define DIMS_B_RAMPING 8'd251
`define DIMS_B_FLASHING 8'd252
`define DIMS_D_MAX 8'd240
`define DIMS_D_RANGE 8'd253
`define DIMS_D_NONE 8'd255
`define DIMS_D_MINBASE 8'd236
`define DIMS_FULL 7'd100
`define DIMS_MEMSEL 8'd250
// message identity
`define DIMS_DGN 17'h1feda
`define DIMS_PRIO 3'd6
// timing
`define DIMS_CLK_NS 10
`define DIMS_SEC_NS 1000000000
`define DIMS_STEP_NS 20000000
`define DIMS_FLASH_NS 500000000
`define DIMS_FLMOM_HALVES 2'd2
`define DIMS_SEC_CYC (`DIMS_SEC_NS / `DIMS_CLK_NS)
`define DIMS_STEP_CYC (`DIMS_STEP_NS / `DIMS_CLK_NS)
`define DIMS_FLASH_CYC (`DIMS_FLASH_NS / `DIMS_CLK_NS)
`endif

// *** bench/dims_load_sva.sv ***
// checker on the ports of the dimmer load block
`default_nettype none
module dims_load_sva (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// bus
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pslverr,
	// outputs
	input wire logic [6:0] level_out,
	input wire logic status_valid,
	input wire logic [63:0] status_data,
	input wire logic [16:0] status_dgn,
	input wire logic [2:0] status_prio
);
	wire [7:0] brt = status_data[23:16];
	wire [7:0] dly = status_data[39:32];
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	a_msg_ident: assert property (status_valid |=> status_dgn == 17'h1feda && status_prio == 3'd6)
		else $error("bad message identity");
	a_resv_ones: assert property (status_valid |-> status_data[63:52] == 12'hfff)
		else $error("reserved bits not ones");
	a_brt_code: assert property (status_valid |-> brt <= 8'd100 || brt == 8'd251 || brt == 8'd252)
		else $error("bad brightness byte");
	a_load_off: assert property (status_valid && brt == 8'h00 |-> status_data[51:50] == 2'b00)
		else $error("load on at zero");
	a_load_on: assert property (status_valid && (brt == 8'd252 || brt inside {[1:100]})
		|-> status_data[51:50] == 2'b01)
		else $error("load off while lit");
	a_send_chg: assert property ($changed(status_data) |-> status_valid)
		else $error("status changed without send");
	a_dly_code: assert property (status_valid |-> dly <= 8'd240 || dly == 8'd253 || dly == 8'd255)
		else $error("bad delay byte");
	a_lvl_max: assert property (level_out <= 7'd100)
		else $error("level above full");
	a_slv_err: assert property (psel && penable && paddr > 8'h13 |-> pslverr)
		else $error("unmapped access accepted");
	a_code_legal: assert property (status_valid |-> status_data[25:24] != 2'b10
		&& status_data[49:48] != 2'b10)
		else $error("illegal two-bit code");
endmodule
bind dims_load dims_load_sva i_sva (.core_clk, .rst_n, .psel, .penable, .paddr, .pslverr,
	.level_out, .status_valid, .status_data, .status_dgn, .status_prio);
`default_nettype wire

// *** bench/dims_net_model.sv ***
// network node that captures dimmer status frames
`default_nettype none
module dims_net_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// status link
	input wire logic status_valid,
	input wire logic [63:0] status_data,
	// last frame seen
	output logic [63:0] msg,
	output int n_msg
);
	timeunit 1ns;
	timeprecision 1ns;
	// reserved bits masked so nothing downstream leans on them
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			msg <= 64'h0;
			n_msg <= 0;
		end else if (status_valid) begin
			msg <= status_data & 64'h000f_ffff_ffff_ffff;
			n_msg <= n_msg + 1;
		end
	end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the dimmer load block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, rst_n, psel, penable, pwrite, ovc_in, override_in, disable_in, slv;
	logic [7:0] paddr;
	logic [31:0] pwdata, rd;
	logic [63:0] msg;
	logic [6:0] x;
	wire [31:0] prdata;
	wire pready, pslverr, status_valid;
	wire [6:0] level_out;
	wire [63:0] status_data;
	wire [16:0] status_dgn;
	wire [2:0] status_prio;
	int n_msg, n_errors, cmp_count;
	dims_load #(.SEC_CYC(20), .STEP_CYC(4), .FLASH_CYC(6)) i_dut (.core_clk, .rst_n, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ovc_in, .override_in, .disable_in,
		.level_out, .status_valid, .status_data, .status_dgn, .status_prio);
	dims_net_model i_net (.core_clk, .rst_n, .status_valid, .status_data, .msg, .n_msg);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic test_done;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cb(input int n, input logic [7:0] e);
		chk({24'h0, msg[8*n +: 8]}, {24'h0, e});
	endtask
	task automatic lv(input logic [6:0] e);
		chk({25'h0, level_out}, {25'h0, e});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (k >= 16) begin
			n_errors++;
			test_done;
		end
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic cmd(input logic [7:0] c, input logic [7:0] l, input logic [7:0] dl, input logic [1:0] ik);
		apb(1'b1, 8'h00, {6'h0, ik, dl, c, l});
		tick(3);
	endtask
	task automatic t_reset;
		cb(0, 8'h01);
		cb(1, 8'h00);
		cb(3, 8'h00);
		cb(4, 8'hff);
		chk(n_msg, 32'h1);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h00011f00);
		apb(1'b1, 8'h08, 32'h0);
		tick(3);
		chk(n_msg, 32'h2);
	endtask
	task automatic t_direct;
		cmd(8'h00, 8'd40, 8'h00, 2'b00);
		lv(7'd40);
		cb(2, 8'd40);
		cb(5, 8'h00);
		cb(6, 8'h04);
		cmd(8'h01, 8'h00, 8'h00, 2'b00);
		lv(7'd100);
		cb(5, 8'h01);
		cmd(8'h03, 8'h00, 8'h00, 2'b00);
		lv(7'd0);
		cb(6, 8'h00);
		cmd(8'h05, 8'd30, 8'h00, 2'b00);
		lv(7'd30);
		cmd(8'h05, 8'd30, 8'h00, 2'b00);
		lv(7'd0);
		cmd(8'h00, 8'd55, 8'h00, 2'b00);
		cmd(8'h06, 8'h00, 8'h00, 2'b00);
		lv(7'd0);
		apb(1'b0, 8'h10, 32'h0);
		chk({25'h0, rd[22:16]}, 32'd55);
		cmd(8'h00, 8'd251, 8'h00, 2'b00);
		lv(7'd55);
		cmd(8'h00, 8'd200, 8'h00, 2'b00);
		lv(7'd100);
	endtask
	task automatic t_delay;
		cmd(8'h03, 8'h00, 8'h00, 2'b00);
		cmd(8'h02, 8'h00, 8'd2, 2'b00);
		cb(4, 8'd2);
		tick(25);
		lv(7'd0);
		tick(20);
		lv(7'd100);
		cb(4, 8'h00);
		cmd(8'h02, 8'h00, 8'd241, 2'b00);
		cb(4, 8'd240);
		cmd(8'h02, 8'h00, 8'd251, 2'b00);
		cb(4, 8'd253);
		cmd(8'h03, 8'h00, 8'h00, 2'b00);
		cb(4, 8'hff);
	endtask
	task automatic t_ramp;
		cmd(8'h11, 8'd10, 8'h00, 2'b00);
		cb(2, 8'd251);
		tick(50);
		lv(7'd10);
		cmd(8'h13, 8'h00, 8'h00, 2'b00);
		tick(12);
		cmd(8'h04, 8'h00, 8'h00, 2'b00);
		x = level_out;
		chk({31'h0, x > 7'd10 && x < 7'd100}, 32'h1);
		tick(10);
		lv(x);
		cmd(8'h04, 8'h00, 8'h00, 2'b00);
		lv(7'd0);
		cmd(8'h00, 8'd8, 8'h00, 2'b00);
		cmd(8'h14, 8'h00, 8'h00, 2'b00);
		cb(6, 8'h00);
		tick(40);
		lv(7'd0);
		cmd(8'h12, 8'd6, 8'h00, 2'b00);
		tick(30);
		lv(7'd6);
		cmd(8'h12, 8'd6, 8'h00, 2'b00);
		tick(30);
		lv(7'd0);
		cmd(8'h15, 8'h00, 8'h00, 2'b00);
		cb(2, 8'd251);
		tick(30);
		chk({31'h0, level_out != 7'd0}, 32'h1);
		cmd(8'h03, 8'h00, 8'h00, 2'b00);
	endtask
	task automatic t_flash;
		cmd(8'h31, 8'h00, 8'h00, 2'b00);
		cb(2, 8'd252);
		cb(6, 8'h04);
		cmd(8'h04, 8'h00, 8'h00, 2'b00);
		lv(7'd0);
		cmd(8'h32, 8'h00, 8'h00, 2'b00);
		cb(2, 8'd252);
		tick(25);
		cb(2, 8'h00);
	endtask
	task automatic t_lock;
		cmd(8'h21, 8'h00, 8'h00, 2'b00);
		cb(3, 8'h01);
		cmd(8'h01, 8'h00, 8'h00, 2'b00);
		lv(7'd0);
		cb(5, 8'h21);
		cmd(8'h22, 8'h00, 8'h00, 2'b00);
		cb(3, 8'h00);
		cmd(8'h01, 8'h00, 8'h00, 2'b01);
		lv(7'd100);
		chk({30'h0, msg[49:48]}, 32'h1);
	endtask
	task automatic t_pins;
		ovc_in <= 1'b1;
		override_in <= 1'b1;
		disable_in <= 1'b1;
		tick(8);
		cb(3, 8'h54);
		ovc_in <= 1'b0;
		override_in <= 1'b0;
		disable_in <= 1'b0;
		tick(8);
		cb(3, 8'h00);
	endtask
	task automatic t_cfg;
		apb(1'b1, 8'h04, 32'h0001007e);
		tick(3);
		cb(1, 8'h7e);
		cb(3, 8'hff);
		chk({30'h0, msg[49:48]}, 32'h3);
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, slv}, 32'h1);
		chk(rd, 32'h0);
	endtask
	initial begin
		{rst_n, psel, penable, pwrite, ovc_in, override_in, disable_in} = 7'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_errors = 0;
		cmp_count = 0;
		tick(5);
		rst_n <= 1'b1;
		tick(4);
		t_reset;
		t_direct;
		t_delay;
		t_ramp;
		t_flash;
		t_lock;
		t_pins;
		t_cfg;
		test_done;
	end
endmodule
`default_nettype wire
